// [core/jtdr_top.sv]
// test data registers, instruction register and serial path of the test port
// Function
// - bypass and boundary registers, plus identification register
// - boundary register: shift path and parallel latch
// - one-bit bypass for bypass, clamp, high-z
// - identification: 32-bit shift plus 32-bit latch
// - identification selected by its instruction or reset state
// - after reset, data scan shifts id lsb first
// - instruction capture shifts out pattern ending 01
// - test reset, synchronised over two stages, abandons any scan
// - id fields: manufacturer, device, version above bit0
// - identification bit zero always one
// - id loaded on capture-dr rising test clock
// - instruction register three bits, shift and latch
`default_nettype none
module jtdr_top #(
    parameter int BSR_LEN = 16, // boundary cells
    parameter logic [3:0] ID_VERSION = 4'h1, // arbitrary value
    parameter logic [15:0] ID_PART = 16'h1234, // arbitrary value
    parameter logic [10:0] ID_MAKER = 11'h055 // arbitrary value
) (
    // system clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // test link pins
    input wire logic TEST_CLOCK_PIN,
    input wire logic TEST_MODE_SELECT_PIN,
    input wire logic TEST_SERIAL_IN_PIN,
    input wire logic TEST_RESET_N_PIN,
    output logic TEST_SERIAL_OUT_PIN,
    output logic TEST_SERIAL_OUT_EN,
    // boundary cells
    input wire logic [BSR_LEN-1:0] BSR_CAPTURE_IN,
    output logic [BSR_LEN-1:0] BSR_PARALLEL_OUT,
    output logic BSR_DRIVE,
    output logic PINS_HIGHZ,
    // identification latch
    output logic [31:0] ID_PARALLEL_OUT
);
    // identification code assembled with the fixed one in bit zero
    localparam logic [31:0] ID_CODE = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

    // timing of the sampled test clock, counted in system clock cycles:
    // a pin edge is seen three edges later, after two sync stages and the history stage
    // each test clock phase must last three system cycles at least, or it is missed
    // mode select and serial in share that delay, so they stay aligned with the edge
    // serial out moves two to three cycles after the pin falls, inside the low phase
    // trade-off: one clock domain only, paid for with a slow test clock

    typedef struct packed {
        logic [2:0] tck_s; // clock sync stages plus edge history
        logic [1:0] tms_s; // mode select sync
        logic [1:0] tdi_s; // serial in sync
        logic [1:0] trst_s; // test reset sync
        logic [BSR_LEN-1:0] bsr_m; // boundary input first stage
        logic [BSR_LEN-1:0] bsr_s; // boundary input second stage
        logic [jtdr_pkg::IR_LEN-1:0] ir_sh; // instruction shift stage
        logic [jtdr_pkg::IR_LEN-1:0] ir_par; // current instruction
        logic bypass; // bypass stage
        logic [BSR_LEN-1:0] bsr_sh; // boundary shift stage
        logic [BSR_LEN-1:0] bsr_par; // boundary latch
        logic [jtdr_pkg::ID_LEN-1:0] id_sh; // identification shift stage
        logic [jtdr_pkg::ID_LEN-1:0] id_par; // identification latch
        logic tdo; // serial out
        logic tdo_en; // serial out driven
        logic drive; // boundary drives pins
        logic highz; // pins floated
    } jtdr_top_s;

    jtdr_top_s st; // registered state
    jtdr_top_s next_st; // next value
    jtdr_pkg::jtdr_tap_e tap_state; // controller state
    logic tck_rise; // test clock rose
    logic tck_fall; // test clock fell
    logic trst_active; // synchronised test reset
    logic [1:0] sel; // selected data register

    // data register chosen by instruction and state
    // codes without a register of their own, the two spare ones included, fall back
    // to the bypass stage, so an unknown instruction still gives a one-bit path
    // the reset state overrides the instruction, so a fresh tester always finds the id
    function automatic logic [1:0] select_dr(input logic [2:0] ins, input jtdr_pkg::jtdr_tap_e s);
        logic [1:0] r;
        r = jtdr_pkg::SEL_BYPASS;
        if (s == jtdr_pkg::TAP_RESET || ins == jtdr_pkg::INS_IDCODE) begin
            r = jtdr_pkg::SEL_ID;
        end else if (ins == jtdr_pkg::INS_EXTEST || ins == jtdr_pkg::INS_SAMPLE) begin
            r = jtdr_pkg::SEL_BSR;
        end
        return r;
    endfunction

    // edges come from the second and third stage, never the first
    // the first stage may still be settling, so only settled bits form an edge
    assign tck_rise = st.tck_s[1] & ~st.tck_s[2];
    assign tck_fall = ~st.tck_s[1] & st.tck_s[2];
    assign trst_active = ~st.trst_s[1];
    assign sel = select_dr(st.ir_par, tap_state);

    // controller state, stepped on test clock rises
    // the follower sees the same edge pulse as the registers, so both move together
    jtdr_tap_fsm u_fsm (
        .clk(CLK_SYS),
        .rst(RST),
        .tck_rise(tck_rise),
        .tms(st.tms_s[1]),
        .trst_active(trst_active),
        .state(tap_state)
    );

    // next state of every register of the block
    always_comb begin
        next_st = st;
        // synchronisers; the test clock is only sampled, hence it must run slowly
        // the boundary inputs are synchronised too, since pins change at any time
        next_st.tck_s = {st.tck_s[1:0], TEST_CLOCK_PIN};
        next_st.tms_s = {st.tms_s[0], TEST_MODE_SELECT_PIN};
        next_st.tdi_s = {st.tdi_s[0], TEST_SERIAL_IN_PIN};
        next_st.trst_s = {st.trst_s[0], TEST_RESET_N_PIN};
        next_st.bsr_m = BSR_CAPTURE_IN;
        next_st.bsr_s = st.bsr_m;
        // pin control follows the current instruction
        // clamp drives the latched boundary values, high-z floats them; both follow
        // the current instruction one cycle late, far below a test clock phase
        next_st.drive = (st.ir_par == jtdr_pkg::INS_EXTEST) || (st.ir_par == jtdr_pkg::INS_CLAMP);
        next_st.highz = (st.ir_par == jtdr_pkg::INS_HIGHZ);
        if (trst_active) begin
            // scan in progress is dropped and serial out released
            // shift stages keep their bits; the next capture overwrites them anyway
            // a link reset lasts three system cycles at least, so no edge slips past it
            next_st.tdo_en = 1'b0;
            next_st.tdo = 1'b0;
            next_st.ir_par = jtdr_pkg::IR_RESET;
        end else if (tck_rise) begin
            case (tap_state)
                jtdr_pkg::TAP_CAP_DR: begin
                    // the bypass stage captures zero, the id its code, the boundary its pins
                    next_st.bypass = 1'b0;
                    if (sel == jtdr_pkg::SEL_ID) begin
                        next_st.id_sh = ID_CODE;
                    end
                    if (sel == jtdr_pkg::SEL_BSR) begin
                        next_st.bsr_sh = st.bsr_s;
                    end
                end
                jtdr_pkg::TAP_SHIFT_DR: begin
                    // only the selected stage moves toward serial out
                    // serial in enters the top of the stage, so bits leave lsb first
                    case (sel)
                        jtdr_pkg::SEL_ID: next_st.id_sh = {st.tdi_s[1], st.id_sh[31:1]};
                        jtdr_pkg::SEL_BSR: next_st.bsr_sh = {st.tdi_s[1], st.bsr_sh[BSR_LEN-1:1]};
                        default: next_st.bypass = st.tdi_s[1];
                    endcase
                end
                // instruction scan: the fixed pattern is loaded, then shifted like data;
                // the current instruction only changes at update, on the falling edge
                jtdr_pkg::TAP_CAP_IR: next_st.ir_sh = jtdr_pkg::IR_CAPTURE;
                jtdr_pkg::TAP_SHIFT_IR: next_st.ir_sh = {st.tdi_s[1], st.ir_sh[2:1]};
                default: next_st.bypass = st.bypass; // other states hold everything
            endcase
        end else if (tck_fall) begin
            // serial out changes on the falling edge so the tester samples it settled
            next_st.tdo_en = (tap_state == jtdr_pkg::TAP_SHIFT_DR) ||
                             (tap_state == jtdr_pkg::TAP_SHIFT_IR);
            // serial out rests low unless a shift state drives a bit below
            next_st.tdo = 1'b0;
            case (tap_state)
                jtdr_pkg::TAP_SHIFT_IR: next_st.tdo = st.ir_sh[0];
                jtdr_pkg::TAP_SHIFT_DR: begin
                    case (sel)
                        jtdr_pkg::SEL_ID: next_st.tdo = st.id_sh[0];
                        jtdr_pkg::SEL_BSR: next_st.tdo = st.bsr_sh[0];
                        default: next_st.tdo = st.bypass;
                    endcase
                end
                jtdr_pkg::TAP_UPD_IR: next_st.ir_par = st.ir_sh;
                jtdr_pkg::TAP_UPD_DR: begin
                    // latches shield parallel outputs from shifting
                    // only the selected register latches; the others keep their outputs
                    if (sel == jtdr_pkg::SEL_BSR) begin
                        next_st.bsr_par = st.bsr_sh;
                    end
                    if (sel == jtdr_pkg::SEL_ID) begin
                        next_st.id_par = st.id_sh;
                    end
                end
                default: next_st.tdo = 1'b0; // not shifting, line at rest
            endcase
        end
        // reset state forces the identification instruction
        // this runs last, so it wins over an update in the same cycle
        if (tap_state == jtdr_pkg::TAP_RESET) begin
            next_st.ir_par = jtdr_pkg::IR_RESET;
        end
    end

    // register update; sync stages reset to idle levels
    // the test reset sync starts released, so leaving system reset gives no link reset
    // the clock history starts low like the idle test clock, so no false edge follows
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            st <= '0;
            st.trst_s <= 2'h3;
            st.ir_par <= jtdr_pkg::IR_RESET;
            st.ir_sh <= jtdr_pkg::IR_CAPTURE;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flops
    // every output is a struct field, so no pin ever sees a combinational glitch
    assign TEST_SERIAL_OUT_PIN = st.tdo;
    assign TEST_SERIAL_OUT_EN = st.tdo_en;
    assign BSR_PARALLEL_OUT = st.bsr_par;
    assign BSR_DRIVE = st.drive;
    assign PINS_HIGHZ = st.highz;
    assign ID_PARALLEL_OUT = st.id_par;
endmodule
`default_nettype wire

// [common/jtdr_pkg.sv]
// shared constants and types for the test data register block
`default_nettype none
package jtdr_pkg;
    // register lengths
    localparam int IR_LEN = 3;
    localparam int ID_LEN = 32;
    // instruction codes
    localparam logic [2:0] INS_EXTEST = 3'h0;
    localparam logic [2:0] INS_IDCODE = 3'h1;
    localparam logic [2:0] INS_SAMPLE = 3'h2;
    localparam logic [2:0] INS_CLAMP = 3'h3;
    localparam logic [2:0] INS_HIGHZ = 3'h4;
    localparam logic [2:0] INS_BYPASS = 3'h7;
    // fixed value captured into the instruction shift stage, low bits 01
    localparam logic [2:0] IR_CAPTURE = 3'h1;
    // instruction held after reset
    localparam logic [2:0] IR_RESET = INS_IDCODE;
    // identification code field positions
    localparam int ID_FIX_POS = 0;
    localparam int ID_MFR_LSB = 1;
    localparam int ID_MFR_LEN = 11;
    localparam int ID_PART_LSB = 12;
    localparam int ID_PART_LEN = 16;
    localparam int ID_VER_LSB = 28;
    localparam int ID_VER_LEN = 4;
    // data register select codes
    localparam logic [1:0] SEL_BYPASS = 2'h0;
    localparam logic [1:0] SEL_BSR = 2'h1;
    localparam logic [1:0] SEL_ID = 2'h2;
    // tap controller states
    typedef enum logic [3:0] {
        TAP_RESET = 4'b0000,
        TAP_IDLE = 4'b0001,
        TAP_SEL_DR = 4'b0010,
        TAP_CAP_DR = 4'b0011,
        TAP_SHIFT_DR = 4'b0100,
        TAP_EX1_DR = 4'b0101,
        TAP_PAUSE_DR = 4'b0110,
        TAP_EX2_DR = 4'b0111,
        TAP_UPD_DR = 4'b1000,
        TAP_SEL_IR = 4'b1001,
        TAP_CAP_IR = 4'b1010,
        TAP_SHIFT_IR = 4'b1011,
        TAP_EX1_IR = 4'b1100,
        TAP_PAUSE_IR = 4'b1101,
        TAP_EX2_IR = 4'b1110,
        TAP_UPD_IR = 4'b1111
    } jtdr_tap_e;
endpackage
`default_nettype wire

// [core/jtdr_tap_fsm.sv]
// tap state follower stepped on each detected test clock rise
`default_nettype none
module jtdr_tap_fsm (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // synchronised link events
    input wire logic tck_rise,
    input wire logic tms,
    input wire logic trst_active,
    // current state
    output jtdr_pkg::jtdr_tap_e state
);
    typedef struct packed {
        jtdr_pkg::jtdr_tap_e state; // controller state
    } jtdr_fsm_s;

    jtdr_fsm_s st; // registered state
    jtdr_fsm_s next_st; // next value

    // next state: test reset wins over any step, abandoning a scan
    always_comb begin
        next_st = st;
        if (trst_active) begin
            next_st.state = jtdr_pkg::TAP_RESET;
        end else if (tck_rise) begin
            case (st.state)
                jtdr_pkg::TAP_RESET: next_st.state = tms ? jtdr_pkg::TAP_RESET : jtdr_pkg::TAP_IDLE;
                jtdr_pkg::TAP_IDLE: next_st.state = tms ? jtdr_pkg::TAP_SEL_DR : jtdr_pkg::TAP_IDLE;
                jtdr_pkg::TAP_SEL_DR: next_st.state = tms ? jtdr_pkg::TAP_SEL_IR : jtdr_pkg::TAP_CAP_DR;
                jtdr_pkg::TAP_CAP_DR: next_st.state = tms ? jtdr_pkg::TAP_EX1_DR : jtdr_pkg::TAP_SHIFT_DR;
                jtdr_pkg::TAP_SHIFT_DR: next_st.state = tms ? jtdr_pkg::TAP_EX1_DR : jtdr_pkg::TAP_SHIFT_DR;
                jtdr_pkg::TAP_EX1_DR: next_st.state = tms ? jtdr_pkg::TAP_UPD_DR : jtdr_pkg::TAP_PAUSE_DR;
                jtdr_pkg::TAP_PAUSE_DR: next_st.state = tms ? jtdr_pkg::TAP_EX2_DR : jtdr_pkg::TAP_PAUSE_DR;
                jtdr_pkg::TAP_EX2_DR: next_st.state = tms ? jtdr_pkg::TAP_UPD_DR : jtdr_pkg::TAP_SHIFT_DR;
                jtdr_pkg::TAP_UPD_DR: next_st.state = tms ? jtdr_pkg::TAP_SEL_DR : jtdr_pkg::TAP_IDLE;
                jtdr_pkg::TAP_SEL_IR: next_st.state = tms ? jtdr_pkg::TAP_RESET : jtdr_pkg::TAP_CAP_IR;
                jtdr_pkg::TAP_CAP_IR: next_st.state = tms ? jtdr_pkg::TAP_EX1_IR : jtdr_pkg::TAP_SHIFT_IR;
                jtdr_pkg::TAP_SHIFT_IR: next_st.state = tms ? jtdr_pkg::TAP_EX1_IR : jtdr_pkg::TAP_SHIFT_IR;
                jtdr_pkg::TAP_EX1_IR: next_st.state = tms ? jtdr_pkg::TAP_UPD_IR : jtdr_pkg::TAP_PAUSE_IR;
                jtdr_pkg::TAP_PAUSE_IR: next_st.state = tms ? jtdr_pkg::TAP_EX2_IR : jtdr_pkg::TAP_PAUSE_IR;
                jtdr_pkg::TAP_EX2_IR: next_st.state = tms ? jtdr_pkg::TAP_UPD_IR : jtdr_pkg::TAP_SHIFT_IR;
                jtdr_pkg::TAP_UPD_IR: next_st.state = tms ? jtdr_pkg::TAP_SEL_DR : jtdr_pkg::TAP_IDLE;
                default: next_st.state = jtdr_pkg::TAP_RESET;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign state = st.state;
endmodule
`default_nettype wire

// [verification/jtdr_asserts.sv]
// port-level assertions for the test data register block
`default_nettype none
module jtdr_asserts #(
    parameter int BSR_LEN = 16
) (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // link pins
    input wire logic TEST_CLOCK_PIN,
    input wire logic TEST_RESET_N_PIN,
    input wire logic TEST_SERIAL_OUT_PIN,
    input wire logic TEST_SERIAL_OUT_EN,
    // parallel stages
    input wire logic [BSR_LEN-1:0] BSR_PARALLEL_OUT,
    input wire logic BSR_DRIVE,
    input wire logic PINS_HIGHZ,
    input wire logic [31:0] ID_PARALLEL_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_SYS); endclocking
    // link reset moves outputs at any time, so its span is left out
    default disable iff (RST || !TEST_RESET_N_PIN);
    a_rst_clears: assert property (disable iff (1'b0) RST |=> !TEST_SERIAL_OUT_EN
        && ID_PARALLEL_OUT == 32'h0000_0000) else $error("reset left outputs active");
    a_trst_stops: assert property (disable iff (RST) !TEST_RESET_N_PIN [*4]
        |=> !TEST_SERIAL_OUT_EN && !TEST_SERIAL_OUT_PIN) else $error("scan not abandoned");
    a_out_quiet: assert property (!TEST_SERIAL_OUT_EN |-> !TEST_SERIAL_OUT_PIN)
        else $error("serial out active while idle");
    // a high phase of three samples cannot hold a fall-driven update
    a_out_holds: assert property (TEST_CLOCK_PIN [*3] |-> $stable(TEST_SERIAL_OUT_PIN)
        && $stable(TEST_SERIAL_OUT_EN)) else $error("serial out moved in high phase");
    a_en_on_fall: assert property ($changed(TEST_SERIAL_OUT_EN)
        |-> !$past(TEST_CLOCK_PIN, 2)) else $error("enable moved away from a fall");
    a_drive_excl: assert property (!(BSR_DRIVE && PINS_HIGHZ))
        else $error("drive and high-z together");
    a_id_latch: assert property ($changed(ID_PARALLEL_OUT)
        |-> !$past(TEST_CLOCK_PIN, 2)) else $error("id latch moved away from a fall");
    a_bsr_latch: assert property ($changed(BSR_PARALLEL_OUT)
        |-> !$past(TEST_CLOCK_PIN, 2)) else $error("boundary latch moved away from a fall");
    // main scenarios reached
    c_shift: cover property ($rose(TEST_SERIAL_OUT_EN));
    c_drive: cover property ($rose(BSR_DRIVE));
    c_highz: cover property ($rose(PINS_HIGHZ));
endmodule
bind jtdr_top jtdr_asserts #(.BSR_LEN(BSR_LEN)) u_jtdr_chk (.CLK_SYS(CLK_SYS), .RST(RST),
    .TEST_CLOCK_PIN(TEST_CLOCK_PIN), .TEST_RESET_N_PIN(TEST_RESET_N_PIN),
    .TEST_SERIAL_OUT_PIN(TEST_SERIAL_OUT_PIN), .TEST_SERIAL_OUT_EN(TEST_SERIAL_OUT_EN),
    .BSR_PARALLEL_OUT(BSR_PARALLEL_OUT), .BSR_DRIVE(BSR_DRIVE), .PINS_HIGHZ(PINS_HIGHZ),
    .ID_PARALLEL_OUT(ID_PARALLEL_OUT));
`default_nettype wire

// [verification/jtdr_tester.sv]
// external boundary-scan tester model driving the test link
`default_nettype none
module jtdr_tester (
    // pacing clock
    input wire logic clk,
    // test link
    input wire logic tdo,
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // link idles with the test clock low
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b1;
    end
    // one 64 ns period; serial out read after the rise, before the shift lands
    task automatic tick(input logic m, input logic d, output logic o);
        @(posedge clk);
        tms <= m;
        tdi <= d;
        repeat (3) @(posedge clk);
        tck <= 1'b1;
        repeat (2) @(posedge clk);
        o = tdo;
        repeat (2) @(posedge clk);
        tck <= 1'b0;
    endtask
    // link reset level, applied at any point of a scan
    task automatic set_reset(input logic v);
        @(posedge clk);
        trst_n <= v;
    endtask
    // instruction scan from idle, returns the captured pattern
    task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
        logic o;
        logic [3:0] pre = 4'h3;
        for (int i = 0; i < 4; i++) tick(pre[i], 1'b0, o);
        for (int i = 0; i < 3; i++) begin
            tick(i == 2, code[i], o);
            cap[i] = o;
        end
        tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b0, o);
    endtask
    // data scan of n bits from idle, lsb first, back to idle
    task automatic scan_dr(input int n, input logic [31:0] din, output logic [31:0] dout);
        logic o;
        dout = 32'h0000_0000;
        tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b0, o);
        tick(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], o);
            dout[i] = o;
        end
        tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b0, o);
    endtask
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench for the test data register block
`default_nettype none
`define CHK(got, exp) begin \
    compares++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("ERROR %0t: got %h expected %h", $time, got, exp); \
    end \
end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // identification fields, arbitrary values
    localparam logic [3:0] ID_VER = 4'h6;
    localparam logic [15:0] ID_PRT = 16'hB00C;
    localparam logic [10:0] ID_MFR = 11'h2A3;
    localparam logic [31:0] ID_EXP = {ID_VER, ID_PRT, ID_MFR, 1'b1};
    localparam logic [15:0] CAP_VAL = 16'hA5C3; // pin values seen by the boundary
    logic CLK_SYS, RST, tck, tms, tdi, trst_n, tdo, tdo_en, bsr_drive, highz;
    logic [15:0] bsr_out;
    logic [31:0] id_out;
    int fail_count = 0;
    int compares = 0;
    // 125 MHz system clock
    initial begin
        CLK_SYS = 1'b0;
        forever #4 CLK_SYS = ~CLK_SYS;
    end
    jtdr_top #(.BSR_LEN(16), .ID_VERSION(ID_VER), .ID_PART(ID_PRT), .ID_MAKER(ID_MFR)) dut (
        .CLK_SYS(CLK_SYS), .RST(RST), .TEST_CLOCK_PIN(tck), .TEST_MODE_SELECT_PIN(tms),
        .TEST_SERIAL_IN_PIN(tdi), .TEST_RESET_N_PIN(trst_n), .TEST_SERIAL_OUT_PIN(tdo),
        .TEST_SERIAL_OUT_EN(tdo_en), .BSR_CAPTURE_IN(CAP_VAL), .BSR_PARALLEL_OUT(bsr_out),
        .BSR_DRIVE(bsr_drive), .PINS_HIGHZ(highz), .ID_PARALLEL_OUT(id_out));
    jtdr_tester tester (.clk(CLK_SYS), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n));
    // first data scan after reset must carry the identification code
    task automatic t_id_reset();
        logic o;
        logic [31:0] got;
        tester.tick(1'b0, 1'b0, o);
        tester.scan_dr(32, 32'hC33C_A55A, got);
        `CHK(got[0], 1'b1)
        `CHK(got[3:0], ID_EXP[3:0])
        `CHK(got, ID_EXP)
        `CHK(id_out, 32'hC33C_A55A)
        $display("test id_reset done");
    endtask
    // every code: capture pattern, selected path, latches and pin modes
    task automatic t_instr_table();
        logic [2:0] cap, code;
        logic [31:0] pat, got, expv;
        int n;
        for (int c = 0; c < 8; c++) begin
            code = 3'(c);
            tester.load_ir(code, cap);
            `CHK(cap[1:0], 2'b01)
            `CHK(cap, jtdr_pkg::IR_CAPTURE)
            n = (code == jtdr_pkg::INS_IDCODE) ? 32 : (code == jtdr_pkg::INS_EXTEST
                || code == jtdr_pkg::INS_SAMPLE) ? 16 : 4;
            pat = 32'h8E3D_51B7 ^ {29'h0, code};
            tester.scan_dr(n, pat, got);
            // bypass: captured zero first, then input lagging one clock
            expv = n == 32 ? ID_EXP : n == 16 ? {16'h0000, CAP_VAL} : {28'h0, pat[2:0], 1'b0};
            `CHK(got, expv)
            if (n == 16) `CHK(bsr_out, pat[15:0])
            if (n == 32) `CHK(id_out, pat)
            `CHK(bsr_drive, code == jtdr_pkg::INS_EXTEST || code == jtdr_pkg::INS_CLAMP)
            `CHK(highz, code == jtdr_pkg::INS_HIGHZ)
        end
        $display("test instr_table done");
    endtask
    // link reset in the middle of a boundary shift
    task automatic t_trst_midscan();
        logic o;
        logic [2:0] cap;
        logic [31:0] got;
        tester.load_ir(jtdr_pkg::INS_SAMPLE, cap);
        for (int i = 0; i < 5; i++) tester.tick(i == 0, 1'b1, o);
        repeat (6) @(posedge CLK_SYS);
        `CHK(tdo_en, 1'b1)
        tester.set_reset(1'b0);
        repeat (5) @(posedge CLK_SYS);
        `CHK(tdo_en, 1'b0)
        `CHK(tdo, 1'b0)
        tester.set_reset(1'b1);
        repeat (4) @(posedge CLK_SYS);
        tester.tick(1'b0, 1'b0, o);
        tester.scan_dr(32, 32'h0F0F_7E81, got);
        `CHK(got, ID_EXP)
        $display("test trst_midscan done");
    endtask
    // verdict in one place
    task automatic report_and_stop();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        RST = 1'b1;
        repeat (16) @(posedge CLK_SYS);
        RST <= 1'b0;
        repeat (4) @(posedge CLK_SYS);
        t_id_reset();
        t_instr_table();
        t_trst_midscan();
        report_and_stop();
    end
    // the tests need about 2300 cycles; a hang is cut well beyond that
    initial begin
        repeat (20000) @(posedge CLK_SYS);
        fail_count++;
        $display("ERROR %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule
`default_nettype wire
